// ===== verilog/bsc_pkg.sv
package bsc_pkg;

   // ==========================================================
   // bus geometry
   localparam int          AXI_ADDR_W          = 8;
   localparam int          AXI_DATA_W          = 32;
   localparam int          AXI_STRB_W          = AXI_DATA_W / 8;
   localparam logic [1:0]  RESP_OKAY           = 2'h0;
   localparam logic [1:0]  RESP_SLVERR         = 2'h2;

   // ==========================================================
   // register offsets (byte addresses, one word each)
   localparam logic [7:0]  OFF_SWITCH_STATUS   = 8'h00;
   localparam logic [7:0]  OFF_SWITCH_CONTROL  = 8'h04;
   localparam logic [7:0]  OFF_UP_LINK_STATUS  = 8'h08;
   localparam logic [7:0]  OFF_DN_LINK_STATUS  = 8'h0C;

   // ==========================================================
   // field positions
   localparam int          SCLK_BIT            = 12;
   localparam int          SOFTWARE_FUNDAMENTAL_RESET_BIT_BIT            = 0;
   localparam int          STS_MODE_LSB        = 0;
   localparam int          STS_CCLK_DN_BIT     = 3;
   localparam int          STS_CCLK_UP_BIT     = 4;
   localparam int          STS_EEPROM_MODE_BIT = 8;
   localparam int          STS_RSVD_MODE_BIT   = 9;
   localparam int          STS_LOAD_BUSY_BIT   = 16;
   localparam int          STS_RUN_BIT         = 17;

   // ==========================================================
   // switch mode encodings
   localparam logic [2:0]  MODE_NORMAL         = 3'h0;
   localparam logic [2:0]  MODE_EEPROM         = 3'h1;

   // ==========================================================
   // reset values and counts
   localparam logic [2:0]  CAP_MODE_RESET      = 3'h0;
   localparam logic        CAP_CCLK_RESET      = 1'b0;
   localparam logic        SCLK_RESET          = 1'b0;
   localparam int          WARM_RESET_CYCLES   = 16;
   localparam int          NUM_DS_PORTS_DEF    = 5;

   // ==========================================================
   // sequencer states
   typedef enum logic [4:0] {
      ST_HOLD   = 5'b00001,
      ST_WARM   = 5'b00010,
      ST_DECODE = 5'b00100,
      ST_LOAD   = 5'b01000,
      ST_RUN    = 5'b10000
   } bsc_state_t;

endpackage : bsc_pkg

// ===== verilog/bsc_sync.sv
`timescale 1ns/1ps

module bsc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   // ==========================================================
   // two-stage synchroniser, first stage feeds only the second
   logic [WIDTH-1:0] stage1_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         stage1_q <= '0;
         syncOut  <= '0;
      end else begin
         stage1_q <= asyncIn;
         syncOut  <= stage1_q;
      end
   end

endmodule : bsc_sync

// ===== verilog/bsc_boot_strap_capture.sv
`timescale 1ns/1ps

// Summary of operation
// RULE1 - straps are latched when the fundamental reset pin deasserts
// RULE2 - strap pins are ignored at every other time
// RULE3 - eeprom loader may override strap-derived values during the reset sequence
// RULE4 - switch status register reads the straps captured at last fundamental reset
// RULE5 - eeprom loader may write any bit of any software-visible register; loader writes only change the slot clock bits and the software reset bit
// RULE6 - downstream common-clock strap seeds every downstream slot clock bit
// RULE7 - downstream slot clock bits stay writable per port after reset
// RULE8 - upstream common-clock strap seeds the upstream slot clock bit
// RULE9 - upstream slot clock bit stays writable after reset
// RULE10 - while reset pin is low all switch logic is held in reset
// RULE11 - mode 0x0 normal, 0x1 normal with eeprom, 0x2 to 0x7 reserved
// RULE12 - board keeps mode straps stable after reset deassertion
// RULE13 - board supplies one 100MHz reference clock
// RULE14 - all internal logic runs from clock derived from reference clock
// RULE15 - software fundamental reset reuses previously captured strap values
// RULE16 - eeprom mode triggers an eeprom load after reset
// RULE17 - reset pin deassertion is synchronised so capture takes one defined cycle
module bsc_boot_strap_capture
#(
   parameter int NUM_DS_PORTS = bsc_pkg::NUM_DS_PORTS_DEF
) (
   input  wire logic                            clk,
   input  wire logic                            rst,
   input  wire logic                            fundamental_reset_n,
   input  wire logic                            common_clock_down_strap,
   input  wire logic                            common_clock_up_strap,
   input  wire logic [2:0]                      switch_mode_strap,
   input  wire logic                            loaderWrValid,
   input  wire logic [bsc_pkg::AXI_ADDR_W-1:0]  loaderWrAddr,
   input  wire logic [bsc_pkg::AXI_DATA_W-1:0]  loaderWrData,
   input  wire logic                            eepromDone,
   output logic                                 coreReset,
   output logic                                 eepromLoadReq,
   output logic                                 modeNormal,
   output logic                                 modeEeprom,
   output logic                                 modeReserved,
   output logic                                 upstreamSlotClock,
   output logic [NUM_DS_PORTS-1:0]              downstreamSlotClock,
   input  wire logic [bsc_pkg::AXI_ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                            s_axi_awvalid,
   output logic                                 s_axi_awready,
   input  wire logic [bsc_pkg::AXI_DATA_W-1:0]  s_axi_wdata,
   input  wire logic [bsc_pkg::AXI_STRB_W-1:0]  s_axi_wstrb,
   input  wire logic                            s_axi_wvalid,
   output logic                                 s_axi_wready,
   output logic [1:0]                           s_axi_bresp,
   output logic                                 s_axi_bvalid,
   input  wire logic                            s_axi_bready,
   input  wire logic [bsc_pkg::AXI_ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                            s_axi_arvalid,
   output logic                                 s_axi_arready,
   output logic [bsc_pkg::AXI_DATA_W-1:0]       s_axi_rdata,
   output logic [1:0]                           s_axi_rresp,
   output logic                                 s_axi_rvalid,
   input  wire logic                            s_axi_rready
);

   import bsc_pkg::*;

   // ==========================================================
   // register map helpers
   localparam int         IDX_DN_BASE = int'(OFF_DN_LINK_STATUS[7:2]);
   localparam int         NUM_REGS    = IDX_DN_BASE + NUM_DS_PORTS;
   localparam int         WARM_W      = $clog2(WARM_RESET_CYCLES + 1);
   localparam int         SCLK_LANE   = SCLK_BIT / 8;
   localparam int         SOFTWARE_FUNDAMENTAL_RESET_BIT_LANE   = SOFTWARE_FUNDAMENTAL_RESET_BIT_BIT / 8;

   function automatic logic regHit(input logic [AXI_ADDR_W-1:0] addr);
      return (addr[1:0] == 2'b00) && (int'(addr[AXI_ADDR_W-1:2]) < NUM_REGS);
   endfunction : regHit

   function automatic logic [AXI_ADDR_W-3:0] regIdx(input logic [AXI_ADDR_W-1:0] addr);
      return addr[AXI_ADDR_W-1:2];
   endfunction : regIdx

   // ==========================================================
   // pin synchronisers
   logic [5:0]            pinsSync;
   logic                  pinSync;
   logic                  dsStrapSync;
   logic                  usStrapSync;
   logic [2:0]            modeStrapSync;
   logic                  pinPrev_q;

   // one clock for everything, taken from the reference clock tree
   bsc_sync #(
      .WIDTH   (6)
   ) u_sync (
      .clk     (clk),
      .rst     (rst),
      .asyncIn ({fundamental_reset_n, common_clock_down_strap,
                 common_clock_up_strap, switch_mode_strap}),
      .syncOut (pinsSync)
   ); // RULE14 RULE17

   assign pinSync       = pinsSync[5];
   assign dsStrapSync   = pinsSync[4];
   assign usStrapSync   = pinsSync[3];
   assign modeStrapSync = pinsSync[2:0];

   always_ff @(posedge clk) begin
      if (rst) begin
         pinPrev_q <= 1'b0;
      end else begin
         pinPrev_q <= pinSync;
      end
   end

   // ==========================================================
   // sequencer
   bsc_state_t            state_q;
   logic [WARM_W-1:0]     warmCnt_q;
   logic [2:0]            capMode_q;
   logic                  capDs_q;
   logic                  capUs_q;
   logic                  deassertEdge;
   logic                  frstWrite;
   logic                  inLoad;
   logic                  inRun;

   assign deassertEdge = pinSync & ~pinPrev_q;
   assign inLoad       = (state_q == ST_LOAD);
   assign inRun        = (state_q == ST_RUN);

   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= ST_HOLD;
      end else if (!pinSync) begin
         state_q <= ST_HOLD; // RULE10
      end else begin
         case (state_q)
            ST_HOLD: begin
               if (deassertEdge) begin
                  state_q <= ST_DECODE;
               end
            end
            ST_WARM: begin
               if (warmCnt_q == '0) begin
                  state_q <= ST_DECODE; // RULE15
               end
            end
            ST_DECODE: begin
               if (capMode_q == MODE_EEPROM) begin
                  state_q <= ST_LOAD; // RULE16
               end else begin
                  state_q <= ST_RUN;
               end
            end
            ST_LOAD: begin
               if (frstWrite) begin
                  state_q <= ST_WARM;
               end else if (eepromDone) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (frstWrite) begin
                  state_q <= ST_WARM;
               end
            end
            default: begin
               state_q <= ST_HOLD;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         warmCnt_q <= '0;
      end else if (frstWrite) begin
         warmCnt_q <= WARM_W'(WARM_RESET_CYCLES - 1);
      end else if (state_q == ST_WARM && warmCnt_q != '0) begin
         warmCnt_q <= warmCnt_q - 1'b1;
      end
   end

   // ==========================================================
   // strap capture

   // sampled in one cycle only; later pin changes never reach the core
   always_ff @(posedge clk) begin
      if (rst) begin
         capMode_q <= CAP_MODE_RESET;
         capDs_q   <= CAP_CCLK_RESET;
         capUs_q   <= CAP_CCLK_RESET;
      end else if (state_q == ST_HOLD && deassertEdge) begin
         capMode_q <= modeStrapSync; // RULE1 RULE2 RULE12
         capDs_q   <= dsStrapSync;   // RULE1 RULE2
         capUs_q   <= usStrapSync;   // RULE1 RULE2
      end
   end

   // ==========================================================
   // mode decode
   always_ff @(posedge clk) begin
      if (rst) begin
         modeNormal   <= 1'b0;
         modeEeprom   <= 1'b0;
         modeReserved <= 1'b0;
      end else if (state_q == ST_DECODE) begin
         modeNormal   <= (capMode_q == MODE_NORMAL); // RULE11
         modeEeprom   <= (capMode_q == MODE_EEPROM); // RULE11
         modeReserved <= (capMode_q != MODE_NORMAL) && (capMode_q != MODE_EEPROM); // RULE11
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         coreReset     <= 1'b1;
         eepromLoadReq <= 1'b0;
      end else begin
         coreReset     <= !pinSync || state_q == ST_HOLD || state_q == ST_WARM; // RULE10
         eepromLoadReq <= pinSync && state_q == ST_DECODE && capMode_q == MODE_EEPROM
                          || pinSync && inLoad && !eepromDone && !frstWrite; // RULE16
      end
   end

   // ==========================================================
   // axi4-lite write channel
   logic                  awHeld_q;
   logic [AXI_ADDR_W-1:0] awAddr_q;
   logic                  wHeld_q;
   logic [AXI_DATA_W-1:0] wData_q;
   logic [AXI_STRB_W-1:0] wStrb_q;
   logic                  loaderGo;
   logic                  axiWrGo;

   // loader has no ready, so a colliding bus write waits one turn
   assign loaderGo      = loaderWrValid & inLoad; // RULE3 RULE5
   assign axiWrGo       = awHeld_q & wHeld_q & ~s_axi_bvalid & ~loaderGo;
   assign s_axi_awready = ~awHeld_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~wHeld_q & ~s_axi_bvalid;

   always_ff @(posedge clk) begin
      if (rst) begin
         awHeld_q <= 1'b0;
         awAddr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld_q <= 1'b1;
         awAddr_q <= s_axi_awaddr;
      end else if (axiWrGo) begin
         awHeld_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wHeld_q <= 1'b0;
         wData_q <= '0;
         wStrb_q <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld_q <= 1'b1;
         wData_q <= s_axi_wdata;
         wStrb_q <= s_axi_wstrb;
      end else if (axiWrGo) begin
         wHeld_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (axiWrGo) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= regHit(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ==========================================================
   // merged register write port
   logic                  wrEn;
   logic [AXI_ADDR_W-3:0] wrIdx;
   logic [AXI_DATA_W-1:0] wrData;
   logic [AXI_STRB_W-1:0] wrStrb;

   always_comb begin
      if (loaderGo) begin
         wrEn   = regHit(loaderWrAddr); // RULE5
         wrIdx  = regIdx(loaderWrAddr);
         wrData = loaderWrData;
         wrStrb = '1;
      end else begin
         wrEn   = axiWrGo && regHit(awAddr_q) && (inRun || inLoad);
         wrIdx  = regIdx(awAddr_q);
         wrData = wData_q;
         wrStrb = wStrb_q;
      end
   end

   // completion is given before the warm reset takes hold
   assign frstWrite = wrEn && wrIdx == OFF_SWITCH_CONTROL[AXI_ADDR_W-1:2]
                      && wrStrb[SOFTWARE_FUNDAMENTAL_RESET_BIT_LANE] && wrData[SOFTWARE_FUNDAMENTAL_RESET_BIT_BIT];

   // ==========================================================
   // slot clock configuration bits
   always_ff @(posedge clk) begin
      if (rst) begin
         upstreamSlotClock <= SCLK_RESET;
      end else if (state_q == ST_DECODE) begin
         upstreamSlotClock <= capUs_q; // RULE8 RULE15
      end else if (wrEn && wrStrb[SCLK_LANE]
                   && wrIdx == OFF_UP_LINK_STATUS[AXI_ADDR_W-1:2]) begin
         upstreamSlotClock <= wrData[SCLK_BIT]; // RULE9 RULE3
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         downstreamSlotClock <= {NUM_DS_PORTS{SCLK_RESET}};
      end else if (state_q == ST_DECODE) begin
         downstreamSlotClock <= {NUM_DS_PORTS{capDs_q}}; // RULE6 RULE15
      end else begin
         for (int p = 0; p < NUM_DS_PORTS; p++) begin
            if (wrEn && wrStrb[SCLK_LANE] && int'(wrIdx) == IDX_DN_BASE + p) begin
               downstreamSlotClock[p] <= wrData[SCLK_BIT]; // RULE7 RULE3
            end
         end
      end
   end

   // ==========================================================
   // axi4-lite read channel
   logic [AXI_DATA_W-1:0] rdMux;
   logic [AXI_ADDR_W-3:0] rdIdx;

   assign s_axi_arready = ~s_axi_rvalid;
   assign rdIdx         = regIdx(s_axi_araddr);

   always_comb begin
      rdMux = '0;
      if (rdIdx == OFF_SWITCH_STATUS[AXI_ADDR_W-1:2]) begin
         rdMux[STS_MODE_LSB +: 3]    = capMode_q; // RULE4
         rdMux[STS_CCLK_DN_BIT]      = capDs_q;   // RULE4
         rdMux[STS_CCLK_UP_BIT]      = capUs_q;   // RULE4
         rdMux[STS_EEPROM_MODE_BIT]  = modeEeprom;
         rdMux[STS_RSVD_MODE_BIT]    = modeReserved;
         rdMux[STS_LOAD_BUSY_BIT]    = inLoad;
         rdMux[STS_RUN_BIT]          = inRun;
      end else if (rdIdx == OFF_UP_LINK_STATUS[AXI_ADDR_W-1:2]) begin
         rdMux[SCLK_BIT] = upstreamSlotClock;
      end else begin
         for (int p = 0; p < NUM_DS_PORTS; p++) begin
            if (int'(rdIdx) == IDX_DN_BASE + p) begin
               rdMux[SCLK_BIT] = downstreamSlotClock[p];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= regHit(s_axi_araddr) ? rdMux : '0;
         s_axi_rresp  <= regHit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : bsc_boot_strap_capture

// ===== dv/bsc_board_model.sv
`timescale 1ns/1ps

module bsc_board_model (
   input  wire logic       clk,
   input  wire logic       holdReq,
   input  wire logic [4:0] strapReq,
   output logic            fundamental_reset_n,
   output logic            common_clock_down_strap,
   output logic            common_clock_up_strap,
   output logic [2:0]      switch_mode_strap
);
   // ==========================================================
   // strap and reset pins
   logic [2:0] mode_q;

   assign fundamental_reset_n     = !holdReq;
   assign common_clock_down_strap = strapReq[3];
   assign common_clock_up_strap   = strapReq[4];
   assign switch_mode_strap       = mode_q;

   // mode pins frozen once reset is released; clock straps may wander freely
   always_ff @(posedge clk) begin
      if (holdReq) begin
         mode_q <= strapReq[2:0];
      end
   end
endmodule : bsc_board_model

// ===== dv/bsc_boot_strap_capture_asserts.sv
`timescale 1ns/1ps

module bsc_boot_strap_capture_asserts
   import bsc_pkg::*;
#(
   parameter int NUM_DS_PORTS = 5
) (
   input  wire logic                           clk,
   input  wire logic                           rst,
   input  wire logic                           fundamental_reset_n,
   input  wire logic                           coreReset,
   input  wire logic                           eepromLoadReq,
   input  wire logic                           modeNormal,
   input  wire logic                           modeEeprom,
   input  wire logic                           modeReserved,
   input  wire logic                           s_axi_awready,
   input  wire logic                           s_axi_wready,
   input  wire logic                           s_axi_bvalid,
   input  wire logic [bsc_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                           s_axi_arvalid,
   input  wire logic                           s_axi_arready,
   input  wire logic                           s_axi_rvalid,
   input  wire logic [1:0]                     s_axi_rresp
);
   // ==========================================================
   // checks
   localparam logic [7:0] LAST_OFF = OFF_DN_LINK_STATUS + 8'(4 * (NUM_DS_PORTS - 1));

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   pin_low_hold_a: assert property (!fundamental_reset_n [*4] |-> coreReset)
      else $error("core not held while reset pin low");
   // two sync flops plus edge detect, so a few cycles of slack
   pin_rise_run_a: assert property ($rose(fundamental_reset_n) |-> ##[1:6] !coreReset)
      else $error("core not released after reset pin rise");
   mode_onehot_a: assert property ($onehot0({modeNormal, modeEeprom, modeReserved}))
      else $error("more than one mode flag set");
   eeprom_load_a: assert property ($rose(modeEeprom) |-> ##[0:2] eepromLoadReq)
      else $error("eeprom mode without load request");
   load_mode_a: assert property (eepromLoadReq |-> modeEeprom && !coreReset)
      else $error("load request outside eeprom mode");
   wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   rd_unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > LAST_OFF
                                   |=> s_axi_rresp == RESP_SLVERR)
      else $error("unmapped read not refused");
endmodule : bsc_boot_strap_capture_asserts

bind bsc_boot_strap_capture bsc_boot_strap_capture_asserts #(.NUM_DS_PORTS(NUM_DS_PORTS)) u_asserts (
   .clk, .rst, .fundamental_reset_n, .coreReset, .eepromLoadReq, .modeNormal, .modeEeprom,
   .modeReserved, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rresp);

// ===== dv/bsc_boot_strap_capture_bench.sv
`timescale 1ns/1ps

module bsc_boot_strap_capture_bench;
   import bsc_pkg::*;
   localparam int NP = 5;
   logic        clk = 0, rst = 1, holdReq = 1, loaderWrValid = 0, eepromDone = 0;
   logic [4:0]  strapReq = 0;
   logic [7:0]  loaderWrAddr = 0, s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] loaderWrData = 0, s_axi_wdata = 0, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb = 0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
   logic        s_axi_arvalid = 0, s_axi_rready = 1;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        coreReset, eepromLoadReq, modeNormal, modeEeprom, modeReserved;
   logic        fundamental_reset_n, common_clock_down_strap, common_clock_up_strap;
   logic        upstreamSlotClock;
   logic [2:0]  switch_mode_strap;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
   logic [NP-1:0] downstreamSlotClock;
   int          badCount = 0, nCompared = 0;

   always #5 clk = ~clk;

   bsc_boot_strap_capture #(.NUM_DS_PORTS(NP)) dut (
      .clk, .rst, .fundamental_reset_n, .common_clock_down_strap, .common_clock_up_strap,
      .switch_mode_strap, .loaderWrValid, .loaderWrAddr, .loaderWrData, .eepromDone,
      .coreReset, .eepromLoadReq, .modeNormal, .modeEeprom, .modeReserved, .upstreamSlotClock,
      .downstreamSlotClock, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);

   bsc_board_model board (.clk, .holdReq, .strapReq, .fundamental_reset_n,
      .common_clock_down_strap, .common_clock_up_strap, .switch_mode_strap);

   // ==========================================================
   // helpers
   task endOfTest();
      $display("compared %0d, mismatches %0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : endOfTest

   task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      nCompared++;
      if (seen !== exp) begin
         badCount++;
         $display("unexpected at %0t ns: %s", $time, msg);
      end
   endtask : chk

   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   // readies sampled at the falling edge; inputs only move on rising edges
   task axiWr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
              output logic [1:0] r);
      logic aw, w, ta, tw;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      aw = 0;
      w = 0;
      while (!(aw && w)) begin
         @(negedge clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         @(posedge clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         aw = aw || ta;
         w = w || tw;
      end
      do @(negedge clk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      @(posedge clk);
   endtask : axiWr

   task axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic t;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      t = 0;
      while (!t) begin
         @(negedge clk);
         t = s_axi_arready;
         @(posedge clk);
      end
      s_axi_arvalid <= 1'b0;
      do @(negedge clk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
   endtask : axiRd

   task ldWr(input logic [7:0] a, input logic [31:0] d);
      loaderWrAddr <= a;
      loaderWrData <= d;
      loaderWrValid <= 1'b1;
      @(posedge clk);
      loaderWrValid <= 1'b0;
   endtask : ldWr

   task waitSt(input int b);
      do axiRd(OFF_SWITCH_STATUS, rd, rs); while (rd[b] !== 1'b1);
   endtask : waitSt

   task boot(input logic [2:0] m, input logic dn, input logic up);
      holdReq <= 1'b1;
      strapReq <= {up, dn, m};
      cyc(6);
      holdReq <= 1'b0;
      cyc(1);
      waitSt(m == MODE_EEPROM ? STS_LOAD_BUSY_BIT : STS_RUN_BIT);
   endtask : boot

   function logic [31:0] stsExp(logic [2:0] m, logic dn, logic up, logic run);
      stsExp = '0;
      stsExp[2:0] = m;
      stsExp[STS_CCLK_DN_BIT] = dn;
      stsExp[STS_CCLK_UP_BIT] = up;
      stsExp[STS_EEPROM_MODE_BIT] = (m == MODE_EEPROM);
      stsExp[STS_RSVD_MODE_BIT] = (m > MODE_EEPROM);
      stsExp[STS_RUN_BIT] = run;
      stsExp[STS_LOAD_BUSY_BIT] = !run;
   endfunction : stsExp

   // ==========================================================
   // tests
   initial begin
      cyc(5);
      rst <= 1'b0;
      for (int m = 0; m < 8; m++) begin
         boot(m[2:0], m[0], !m[1]);
         axiRd(OFF_SWITCH_STATUS, rd, rs);
         chk(rd, stsExp(m[2:0], m[0], !m[1], m != 1), "status after boot");
         chk({modeNormal, modeEeprom, modeReserved}, {m == 0, m == 1, m > 1}, "mode");
         chk(upstreamSlotClock, !m[1], "upstream seed");
         chk(downstreamSlotClock, {NP{m[0]}}, "downstream seed");
         if (m == 1) begin
            chk(eepromLoadReq, 1'b1, "load request");
            ldWr(OFF_DN_LINK_STATUS + 8'h08, 32'h0000_0000);
            cyc(1);
            ldWr(OFF_UP_LINK_STATUS, 32'h0000_0000);
            eepromDone <= 1'b1;
            cyc(1);
            eepromDone <= 1'b0;
            waitSt(STS_RUN_BIT);
            chk(downstreamSlotClock, 5'b11011, "loader down write");
            chk(upstreamSlotClock, 1'b0, "loader up write");
         end
         $display("test boot mode %0d done", m);
      end
      // straps moved while running must be ignored
      strapReq <= {1'b1, 1'b0, 3'h2};
      cyc(10);
      axiRd(OFF_SWITCH_STATUS, rd, rs);
      chk(rd, stsExp(3'h7, 1'b1, 1'b0, 1'b1), "status kept");
      chk(downstreamSlotClock, 5'b11111, "slot clocks kept");
      for (int p = 0; p < NP; p++) begin
         axiWr(OFF_DN_LINK_STATUS + 8'(4 * p), {19'b0, p[0], 12'b0}, 4'hF, rs);
         chk(rs, RESP_OKAY, "down write response");
         axiRd(OFF_DN_LINK_STATUS + 8'(4 * p), rd, rs);
         chk(rd[SCLK_BIT], p[0], "down readback");
      end
      chk(downstreamSlotClock, 5'b01010, "down per port");
      axiWr(OFF_UP_LINK_STATUS, 32'h0000_1000, 4'hF, rs);
      axiWr(OFF_UP_LINK_STATUS, 32'h0000_0000, 4'h1, rs);
      axiRd(OFF_UP_LINK_STATUS, rd, rs);
      chk(rd[SCLK_BIT], 1'b1, "up readback");
      chk(upstreamSlotClock, 1'b1, "up write");
      axiWr(8'h20, 32'hFFFF_FFFF, 4'hF, rs);
      chk(rs, RESP_SLVERR, "unmapped write");
      axiRd(8'h20, rd, rs);
      chk(rd, 32'h0000_0000, "unmapped data");
      chk(rs, RESP_SLVERR, "unmapped read");
      $display("test register access done");
      axiWr(OFF_SWITCH_CONTROL, 32'h0000_0001, 4'h1, rs);
      chk(rs, RESP_OKAY, "soft reset response");
      @(negedge clk);
      chk(coreReset, 1'b1, "soft reset holds core");
      @(posedge clk);
      waitSt(STS_RUN_BIT);
      chk(rd, stsExp(3'h7, 1'b1, 1'b0, 1'b1), "no resample");
      chk(downstreamSlotClock, 5'b11111, "down reload");
      chk(upstreamSlotClock, 1'b0, "up reload");
      axiRd(OFF_SWITCH_CONTROL, rd, rs);
      chk(rd[SOFTWARE_FUNDAMENTAL_RESET_BIT_BIT], 1'b0, "control reads zero");
      $display("test software reset done");
      endOfTest();
   end

   // whole run needs a few thousand cycles at most
   initial begin
      #200_000;
      badCount++;
      $display("unexpected at %0t ns: watchdog expired", $time);
      endOfTest();
   end
endmodule : bsc_boot_strap_capture_bench
